// >>> hw/tsaf_parser.sv
// Adaptation field parser with AHB-Lite register access
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "tsaf_regs.svh"
module tsaf_parser #(
	parameter int PAW = 8
)(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic ts_valid,
	input wire tsaf_pkg::tsaf_byte_t ts_data,
	output logic pay_valid,
	output tsaf_pkg::tsaf_byte_t pay_data,
	output logic pcr_valid,
	output logic [32:0] pcr_base,
	output logic [8:0] pcr_ext,
	output logic disc_evt,
	output logic rand_evt,
	output logic irq
);
	import tsaf_pkg::*;

	typedef struct packed {
		logic [1:0] ctrl;
		logic [`TSAF_NUM_EVT-1:0] stat;
		logic [`TSAF_NUM_EVT-1:0] mask;
		tsaf_state_e st;
		logic [7:0] pos;
		logic [7:0] left;
		logic [7:0] sub;
		logic [7:0] flags;
		logic [47:0] sh;
		logic [47:0] pcr;
		logic [47:0] opcr;
		logic [31:0] ts;
		logic [31:0] now;
		logic [7:0] plen;
		logic [7:0] pcnt;
		logic [PAW-1:0] rptr;
		logic [7:0] flg_r;
		logic wr_ph;
		logic rd_ph;
		logic [7:0] aoff;
		logic [31:0] hrdata;
		logic pay_valid;
		logic [7:0] pay_data;
		logic pcr_valid;
		logic [32:0] pcr_base;
		logic [8:0] pcr_ext;
		logic disc_evt;
		logic rand_evt;
		logic irq;
		logic v1;
		logic v2;
		logic [7:0] d1;
		logic [7:0] d2;
	} tsaf_state_s;

	tsaf_state_s s_r;
	tsaf_state_s s_nxt;
	tsaf_mem_if #(.AW(PAW)) mi ();

	tsaf_priv_mem #(.AW(PAW)) u_mem (
		.hclk(hclk),
		.ce(ce),
		.m(mi)
	);

	// Splits a clock field into base and extension, skipping reserved bits
	function automatic logic [41:0] clkref(input logic [47:0] f);
		clkref = {f[47:15], f[8:0]};
	endfunction

	logic acc;
	logic [7:0] b;
	logic bv;
	logic [`TSAF_NUM_EVT-1:0] ev;

	assign acc = hsel && hready && htrans[1];
	assign b = s_r.d2;
	assign bv = s_r.v2;

	assign mi.we = bv && s_r.st == TSAF_PRIV;
	assign mi.waddr = s_r.pcnt[PAW-1:0];
	assign mi.wdata = b;
	// Read one ahead so a pop issued right after the previous pop's data phase gets the next byte
	assign mi.raddr = s_nxt.rptr;

	always_comb
	begin
		s_nxt = s_r;
		ev = '0;
		s_nxt.v1 = ts_valid;
		s_nxt.d1 = ts_data;
		s_nxt.v2 = s_r.v1;
		s_nxt.d2 = s_r.d1;
		s_nxt.now = s_r.now + 32'h1;
		s_nxt.pay_valid = 1'b0;
		s_nxt.pcr_valid = 1'b0;
		s_nxt.disc_evt = 1'b0;
		s_nxt.rand_evt = 1'b0;
		if (bv && s_r.ctrl[`TSAF_CTRL_ENABLE])
		begin
			s_nxt.pos = s_r.pos + 8'h1;
			s_nxt.left = s_r.left - 8'h1;
			case (s_r.st)
				TSAF_HUNT:
				begin
					if (b == `TSAF_SYNC)
					begin
						s_nxt.st = TSAF_LINK;
						s_nxt.pos = 8'h1;
					end
				end
				TSAF_LINK:
				begin
					if (s_r.pos == `TSAF_LINK_HDR_BYTES - 8'h1)
					begin
						s_nxt.left = `TSAF_PKT_BYTES - `TSAF_LINK_HDR_BYTES;
						if (b[5])
							s_nxt.st = TSAF_LEN;
						else
							s_nxt.st = TSAF_PAYLOAD;
						s_nxt.sub = {7'h0, b[4]};
					end
				end
				TSAF_LEN:
				begin
					s_nxt.left = b;
					if (b == 8'h0)
						s_nxt.st = s_r.sub[0] ? TSAF_PAYLOAD : TSAF_SKIP;
					else if (s_r.ctrl[`TSAF_CTRL_BYPASS])
						s_nxt.st = TSAF_SKIP;
					else
						s_nxt.st = TSAF_FLAGS;
					if (b == 8'h0)
						s_nxt.left = 8'hff;
					s_nxt.flags = s_r.sub;
				end
				TSAF_FLAGS:
				begin
					s_nxt.flg_r = b;
					s_nxt.flags = {b[7:5], b[4:0]};
					if (b[`TSAF_FL_DISC])
					begin
						s_nxt.disc_evt = 1'b1;
						ev[`TSAF_ST_DISC] = 1'b1;
					end
					if (b[`TSAF_FL_RAND])
					begin
						s_nxt.rand_evt = 1'b1;
						ev[`TSAF_ST_RAND] = 1'b1;
					end
					s_nxt.sub = 8'h0;
					s_nxt.pcnt = 8'h0;
					s_nxt.st = TSAF_SKIP;
					if (b[`TSAF_FL_PCR] || b[`TSAF_FL_OPCR])
						s_nxt.st = TSAF_CLK;
					else if (b[`TSAF_FL_SPLICE])
						s_nxt.st = TSAF_SPLICE;
					else if (b[`TSAF_FL_PRIV])
						s_nxt.st = TSAF_PRIV_LEN;
					else if (b[`TSAF_FL_EXT])
						s_nxt.st = TSAF_EXT_LEN;
				end
				TSAF_CLK:
				begin
					s_nxt.sh = {s_r.sh[39:0], b};
					s_nxt.sub = s_r.sub + 8'h1;
					if (s_r.sub == `TSAF_CLKREF_BYTES - 8'h1)
					begin
						s_nxt.sub = 8'h0;
						if (s_r.flags[`TSAF_FL_PCR])
						begin
							s_nxt.ts = s_r.now;
							s_nxt.pcr = {s_r.sh[39:0], b};
							{s_nxt.pcr_base, s_nxt.pcr_ext} =
								clkref({s_r.sh[39:0], b});
							s_nxt.pcr_valid = 1'b1;
							ev[`TSAF_ST_PCR] = 1'b1;
							s_nxt.flags[`TSAF_FL_PCR] = 1'b0;
						end
						else
						begin
							s_nxt.opcr = {s_r.sh[39:0], b};
							ev[`TSAF_ST_OPCR] = 1'b1;
							s_nxt.flags[`TSAF_FL_OPCR] = 1'b0;
						end
						if (s_r.flags[`TSAF_FL_PCR] &&
							s_r.flags[`TSAF_FL_OPCR])
							s_nxt.st = TSAF_CLK;
						else if (s_r.flags[`TSAF_FL_SPLICE])
							s_nxt.st = TSAF_SPLICE;
						else if (s_r.flags[`TSAF_FL_PRIV])
							s_nxt.st = TSAF_PRIV_LEN;
						else if (s_r.flags[`TSAF_FL_EXT])
							s_nxt.st = TSAF_EXT_LEN;
						else
							s_nxt.st = TSAF_SKIP;
					end
				end
				TSAF_SPLICE:
				begin
					if (s_r.flags[`TSAF_FL_PRIV])
						s_nxt.st = TSAF_PRIV_LEN;
					else if (s_r.flags[`TSAF_FL_EXT])
						s_nxt.st = TSAF_EXT_LEN;
					else
						s_nxt.st = TSAF_SKIP;
				end
				TSAF_PRIV_LEN:
				begin
					s_nxt.plen = b;
					s_nxt.pcnt = 8'h0;
					if (b != 8'h0)
						s_nxt.st = TSAF_PRIV;
					else if (s_r.flags[`TSAF_FL_EXT])
						s_nxt.st = TSAF_EXT_LEN;
					else
						s_nxt.st = TSAF_SKIP;
				end
				TSAF_PRIV:
				begin
					s_nxt.pcnt = s_r.pcnt + 8'h1;
					if (s_r.pcnt == s_r.plen - 8'h1)
					begin
						ev[`TSAF_ST_PRIV] = 1'b1;
						if (s_r.flags[`TSAF_FL_EXT])
							s_nxt.st = TSAF_EXT_LEN;
						else
							s_nxt.st = TSAF_SKIP;
					end
				end
				TSAF_EXT_LEN:
				begin
					s_nxt.st = TSAF_SKIP;
				end
				TSAF_SKIP:
				begin
					if (s_r.left == 8'h1)
						s_nxt.st = TSAF_PAYLOAD;
				end
				TSAF_PAYLOAD:
				begin
					s_nxt.pay_valid = 1'b1;
					s_nxt.pay_data = b;
				end
				default:
					s_nxt.st = TSAF_HUNT;
			endcase
			if (s_r.st != TSAF_HUNT && s_r.st != TSAF_LINK &&
				s_r.st != TSAF_LEN && s_r.st != TSAF_PAYLOAD &&
				s_r.left == 8'h1)
			begin
				// A field still short of bytes overran the length
				if (s_nxt.st != TSAF_SKIP && s_nxt.st != TSAF_PAYLOAD)
					ev[`TSAF_ST_LEN_ERR] = 1'b1;
				s_nxt.st = TSAF_PAYLOAD;
			end
			// Packet ends after its last byte
			if (s_r.pos == `TSAF_PKT_BYTES - 8'h1)
			begin
				s_nxt.st = TSAF_HUNT;
				s_nxt.pos = 8'h0;
			end
		end
		// Bus address phase
		s_nxt.wr_ph = acc && hwrite;
		s_nxt.rd_ph = acc && !hwrite;
		if (acc)
			s_nxt.aoff = haddr[7:0];
		if (s_r.wr_ph)
		begin
			if (s_r.aoff == `TSAF_OFF_CTRL)
				s_nxt.ctrl = hwdata[1:0];
			else if (s_r.aoff == `TSAF_OFF_STATUS)
				s_nxt.stat = s_r.stat & ~hwdata[`TSAF_NUM_EVT-1:0];
			else if (s_r.aoff == `TSAF_OFF_MASK)
				s_nxt.mask = hwdata[`TSAF_NUM_EVT-1:0];
		end
		if (s_r.rd_ph && s_r.aoff == `TSAF_OFF_PRIV_POP)
			s_nxt.rptr = s_r.rptr + 1'b1;
		if (ev[`TSAF_ST_PRIV])
			s_nxt.rptr = '0;
		// Set wins over clear
		s_nxt.stat = s_nxt.stat | ev;
		s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
		s_nxt.hrdata = 32'h0;
		if (acc && !hwrite)
		begin
			if (haddr[7:0] == `TSAF_OFF_CTRL)
				s_nxt.hrdata = {30'h0, s_r.ctrl};
			else if (haddr[7:0] == `TSAF_OFF_STATUS)
				s_nxt.hrdata = {26'h0, s_r.stat};
			else if (haddr[7:0] == `TSAF_OFF_MASK)
				s_nxt.hrdata = {26'h0, s_r.mask};
			else if (haddr[7:0] == `TSAF_OFF_PCR_HI)
				s_nxt.hrdata = {16'h0, s_r.pcr[47:32]};
			else if (haddr[7:0] == `TSAF_OFF_PCR_LO)
				s_nxt.hrdata = s_r.pcr[31:0];
			else if (haddr[7:0] == `TSAF_OFF_OPCR_HI)
				s_nxt.hrdata = {16'h0, s_r.opcr[47:32]};
			else if (haddr[7:0] == `TSAF_OFF_OPCR_LO)
				s_nxt.hrdata = s_r.opcr[31:0];
			else if (haddr[7:0] == `TSAF_OFF_PCR_TS)
				s_nxt.hrdata = s_r.ts;
			else if (haddr[7:0] == `TSAF_OFF_FLAGS)
				s_nxt.hrdata = {24'h0, s_r.flg_r};
			else if (haddr[7:0] == `TSAF_OFF_PRIV)
				s_nxt.hrdata = {24'h0, s_r.plen};
			else if (haddr[7:0] == `TSAF_OFF_PRIV_POP)
				s_nxt.hrdata = {24'h0, mi.rdata};
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_r <= '0;
			s_r.ctrl <= `TSAF_CTRL_RESET;
			s_r.st <= TSAF_HUNT;
		end
		else if (ce)
			s_r <= s_nxt;
	end

	assign hrdata = s_r.hrdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign pay_valid = s_r.pay_valid;
	assign pay_data = s_r.pay_data;
	assign pcr_valid = s_r.pcr_valid;
	assign pcr_base = s_r.pcr_base;
	assign pcr_ext = s_r.pcr_ext;
	assign disc_evt = s_r.disc_evt;
	assign rand_evt = s_r.rand_evt;
	assign irq = s_r.irq;
endmodule

// >>> hw/tsaf_regs.svh
// Register map, field positions and constants of the adaptation field parser
// How it works
// - Length byte counts every following header byte
// - Trailing 0xff stuffing bytes are discarded unread
// - Bypass mode skips header to payload
// - Last five flags mark optional fields present
// - First three flags add no bytes
// - Optional fields parsed in flag order
// - Discontinuity flag raises clock realign event
// - Random access flag reports entry point
// - Stream priority flag is not acted on, only kept in the flags register
// - Original clock reference extracted, not recovered
// - Extension counts 0..299, base 33 bits
// - Timestamp clock reference at last extension byte
// - Private data bytes passed through uninterpreted
// - Extension bytes skipped without acting
// - Parse only when adaptation control 10/11
`ifndef TSAF_REGS_SVH
`define TSAF_REGS_SVH
`define TSAF_OFF_CTRL 8'h00
`define TSAF_OFF_STATUS 8'h04
`define TSAF_OFF_MASK 8'h08
`define TSAF_OFF_PCR_HI 8'h0c
`define TSAF_OFF_PCR_LO 8'h10
`define TSAF_OFF_OPCR_HI 8'h14
`define TSAF_OFF_OPCR_LO 8'h18
`define TSAF_OFF_PCR_TS 8'h1c
`define TSAF_OFF_FLAGS 8'h20
`define TSAF_OFF_PRIV 8'h24
`define TSAF_OFF_PRIV_POP 8'h28
`define TSAF_CTRL_ENABLE 0
`define TSAF_CTRL_BYPASS 1
`define TSAF_CTRL_RESET 2'h1
`define TSAF_ST_PCR 0
`define TSAF_ST_OPCR 1
`define TSAF_ST_DISC 2
`define TSAF_ST_RAND 3
`define TSAF_ST_PRIV 4
`define TSAF_ST_LEN_ERR 5
`define TSAF_NUM_EVT 6
`define TSAF_FL_DISC 7
`define TSAF_FL_RAND 6
`define TSAF_FL_PCR 4
`define TSAF_FL_OPCR 3
`define TSAF_FL_SPLICE 2
`define TSAF_FL_PRIV 1
`define TSAF_FL_EXT 0
`define TSAF_LINK_HDR_BYTES 8'd4
`define TSAF_PKT_BYTES 8'd188
`define TSAF_SYNC 8'h47
`define TSAF_CLKREF_BYTES 8'd6
`define TSAF_STUFF 8'hff
`define TSAF_EXT_WRAP 9'd299
`endif

// >>> hw/tsaf_pkg.sv
// Types shared by the adaptation field parser modules
package tsaf_pkg;
	typedef enum logic [3:0] {
		TSAF_HUNT,
		TSAF_LINK,
		TSAF_LEN,
		TSAF_FLAGS,
		TSAF_CLK,
		TSAF_SPLICE,
		TSAF_PRIV_LEN,
		TSAF_PRIV,
		TSAF_EXT_LEN,
		TSAF_SKIP,
		TSAF_PAYLOAD
	} tsaf_state_e;
	typedef logic [7:0] tsaf_byte_t;
endpackage

// >>> hw/tsaf_mem_if.sv
// Write and read ports of the private data buffer
`timescale 1ns/10ps
interface tsaf_mem_if #(parameter int AW = 8);
	logic we;
	logic [AW-1:0] waddr;
	logic [7:0] wdata;
	logic [AW-1:0] raddr;
	logic [7:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr,
		input rdata);
	modport mem (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface

// >>> hw/tsaf_priv_mem.sv
// Small byte memory holding the private data of the last packet
`timescale 1ns/10ps
module tsaf_priv_mem #(
	parameter int AW = 8
)(
	input wire logic hclk,
	input wire logic ce,
	tsaf_mem_if.mem m
);
	logic [7:0] mem [0:(1<<AW)-1];
	logic [7:0] rdata_r;
	always_ff @(posedge hclk)
	begin
		if (ce)
		begin
			if (m.we)
				mem[m.waddr] <= m.wdata;
			rdata_r <= mem[m.raddr];
		end
	end
	assign m.rdata = rdata_r;
endmodule

// >>> tb/tsaf_modem.sv
// Behavioural byte source standing in for the channel decoder
`timescale 1ns/10ps
module tsaf_modem (
	input wire logic hclk,
	output logic ts_valid,
	output logic [7:0] ts_data
);
	logic [7:0] q[$];
	logic slow = 1'b0;
	initial
	begin
		ts_valid = 1'b0;
		ts_data = 8'h00;
	end
	// Queued packets sent as built, idle cycles randomly inserted when slow
	always @(posedge hclk)
	begin
		if (q.size() != 0 && !(slow && $urandom_range(1) != 0))
		begin
			ts_valid <= 1'b1;
			ts_data <= q.pop_front();
		end
		else
		begin
			ts_valid <= 1'b0;
			ts_data <= ~ts_data;
		end
	end
endmodule

// >>> tb/tsaf_parser_assertions.sv
// Concurrent checks on the parser stream outputs
`timescale 1ns/10ps
module tsaf_parser_assertions (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ts_valid,
	input wire tsaf_pkg::tsaf_byte_t ts_data,
	input wire logic pay_valid,
	input wire logic pcr_valid,
	input wire logic [32:0] pcr_base,
	input wire logic [8:0] pcr_ext,
	input wire logic disc_evt,
	input wire logic rand_evt
);
	import tsaf_pkg::*;
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	property p_pay;
		pay_valid |-> $past(ts_valid, 3);
	endproperty
	a_pay: assert property (p_pay) else $error("pay no byte");
	property p_pcr;
		pcr_valid |-> $past(ts_valid, 3) && !pay_valid;
	endproperty
	a_pcr: assert property (p_pcr) else $error("pcr timing");
	property p_hold;
		!pcr_valid |-> $stable(pcr_base) && $stable(pcr_ext);
	endproperty
	a_hold: assert property (p_hold) else $error("pcr moved");
	property p_ext;
		pcr_valid |-> pcr_ext <= 9'd299;
	endproperty
	a_ext: assert property (p_ext) else $error("ext range");
	property p_disc;
		disc_evt |-> $past(ts_data[7], 3) ##1 !disc_evt;
	endproperty
	a_disc: assert property (p_disc) else $error("disc evt");
	property p_rand;
		rand_evt |-> $past(ts_data[6], 3) ##1 !rand_evt;
	endproperty
	a_rand: assert property (p_rand) else $error("rand evt");
	property p_pair;
		disc_evt |-> rand_evt == $past(ts_data[6], 3);
	endproperty
	a_pair: assert property (p_pair) else $error("evt pair");
	property p_nopay;
		disc_evt || rand_evt |-> !pay_valid && !pcr_valid;
	endproperty
	a_nopay: assert property (p_nopay) else $error("flags as pay");
endmodule
bind tsaf_parser tsaf_parser_assertions u_sva (.*);

// >>> tb/tb_ts_adaptation_field_parser.sv
// Self-checking bench for the adaptation field parser
`timescale 1ns/10ps
module tb_ts_adaptation_field_parser;
	import tsaf_pkg::*;
	logic hclk, hresetn, hsel, hwrite, ts_valid, pay_valid, pcr_valid;
	logic disc_evt, rand_evt, irq, hreadyout, hresp;
	logic ce;
	logic [2:0] hsize;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [32:0] pcr_base, pb, ob;
	logic [8:0] pcr_ext, pe, oe;
	tsaf_byte_t ts_data, pay_data;
	logic [7:0] ex[$], pq[$];
	int fail_count, n_checks, cyc, n_pcr, n_disc, n_rand;
	tsaf_parser DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.ts_valid(ts_valid), .ts_data(ts_data), .pay_valid(pay_valid),
		.pay_data(pay_data), .pcr_valid(pcr_valid), .pcr_base(pcr_base),
		.pcr_ext(pcr_ext), .disc_evt(disc_evt), .rand_evt(rand_evt),
		.irq(irq));
	tsaf_modem m (.hclk(hclk), .ts_valid(ts_valid), .ts_data(ts_data));
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [47:0] e, input logic [47:0] g);
		n_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	always @(posedge hclk)
	begin
		cyc++;
		n_pcr += (pcr_valid === 1'b1);
		n_disc += (disc_evt === 1'b1);
		n_rand += (rand_evt === 1'b1);
		if (pay_valid === 1'b1)
			chk("pay", ex.size() ? ex.pop_front() : 48'h100, pay_data);
		if (cyc == 30000)
		begin
			fail_count++;
			give_verdict;
		end
	end
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task rchk(input string n, input logic [31:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(n, e, rd);
		chk("resp", 0, hresp);
	endtask
	task automatic pay(input int n);
		logic [7:0] b;
		repeat (n)
		begin
			b = 8'($urandom);
			m.q.push_back(b);
			ex.push_back(b);
		end
	endtask
	task push4(input logic [31:0] w);
		for (int i = 3; i >= 0; i--)
			m.q.push_back(w[i*8 +: 8]);
	endtask
	task evchk(input int p, input int d, input int r);
		chk("npcr", p, n_pcr);
		chk("ndisc", d, n_disc);
		chk("nrand", r, n_rand);
	endtask
	task push6(input logic [47:0] f);
		for (int i = 5; i >= 0; i--)
			m.q.push_back(f[i*8 +: 8]);
	endtask
	task automatic pkt(input logic [1:0] c, input logic [7:0] fl,
		input int np, input int ne, input int ns);
		int ln;
		logic [7:0] b;
		ln = 0;
		m.q.push_back(8'h47);
		m.q.push_back(8'h01);
		m.q.push_back(8'h00);
		m.q.push_back({2'b00, c, 4'h0});
		if (c[1])
		begin
			ln = 1 + 6 * fl[4] + 6 * fl[3] + fl[2];
			ln = ln + (fl[1] ? np + 1 : 0) + (fl[0] ? ne + 1 : 0);
			if (!c[0])
				ns = 183 - ln;
			m.q.push_back(8'(ln + ns));
			m.q.push_back(fl);
			if (fl[4])
				push6({pb, 6'h3f, pe});
			if (fl[3])
				push6({ob, 6'h3f, oe});
			if (fl[2])
				m.q.push_back(8'h05);
			if (fl[1])
				m.q.push_back(8'(np));
			repeat (fl[1] ? np : 0)
			begin
				b = 8'($urandom);
				m.q.push_back(b);
				pq.push_back(b);
			end
			if (fl[0])
				m.q.push_back(8'(ne));
			repeat (fl[0] ? ne : 0) m.q.push_back(8'($urandom));
			repeat (ns) m.q.push_back(8'hff);
			ln = ln + ns + 1;
		end
		pay(184 - ln);
	endtask
	task drain;
		while (m.q.size() != 0)
			@(posedge hclk);
		repeat (8) @(posedge hclk);
		chk("left", 0, ex.size());
	endtask
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		hsize = 3'b000;
		ce = 1'b1;
		void'($urandom(14035));
		pb = 33'({$urandom, $urandom});
		ob = 33'({$urandom, $urandom});
		pe = 9'($urandom_range(299));
		oe = 9'($urandom_range(299));
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rchk("ctrl", 32'h00, 32'h1);
		rchk("unmap", 32'h40, 32'h0);
		pkt(2'b11, 8'hff, 2, 1, 3);
		drain;
		evchk(1, 1, 1);
		chk("base", pb, pcr_base);
		chk("ext", pe, pcr_ext);
		rchk("pchi", 32'h0c, 32'(pb[32:17]));
		rchk("pclo", 32'h10, {pb[16:0], 6'h3f, pe});
		rchk("stat", 32'h04, 32'h1f);
		rchk("ophi", 32'h14, 32'(ob[32:17]));
		rchk("oplo", 32'h18, {ob[16:0], 6'h3f, oe});
		rchk("flags", 32'h20, 32'hff);
		rchk("plen", 32'h24, 32'h2);
		rchk("pop0", 32'h28, {24'h0, pq[0]});
		rchk("pop1", 32'h28, {24'h0, pq[1]});
		chk("irq", 0, irq);
		ahb(1'b1, 32'h08, 32'h4);
		repeat (3) @(posedge hclk);
		chk("irq", 1, irq);
		ahb(1'b1, 32'h04, 32'h1f);
		repeat (3) @(posedge hclk);
		chk("irq", 0, irq);
		pkt(2'b10, 8'h20, 0, 0, 0);
		pkt(2'b01, 8'h00, 0, 0, 0);
		drain;
		evchk(1, 1, 1);
		rchk("stat", 32'h04, 32'h0);
		pkt(2'b11, 8'h10, 0, 0, 0);
		push4(32'h47010030);
		push4(32'h03101234);
		pay(180);
		drain;
		evchk(2, 1, 1);
		rchk("stat", 32'h04, 32'h21);
		ahb(1'b1, 32'h04, 32'h21);
		ce <= 1'b0;
		ahb(1'b1, 32'h08, 32'h3f);
		ce <= 1'b1;
		rchk("mask", 32'h08, 32'h4);
		ahb(1'b1, 32'h00, 32'h3);
		m.slow <= 1'b1;
		pkt(2'b11, 8'hd0, 0, 0, 4);
		drain;
		evchk(2, 1, 1);
		rchk("stat", 32'h04, 32'h0);
		give_verdict;
	end
endmodule
